// ==== core/rpm_pkg.sv ====
package rpm_pkg;
	// Register byte offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_ID = 8'h08;
	localparam logic [7:0] A_TRAIN = 8'h0c;
	localparam logic [7:0] A_STN_LO = 8'h10;
	localparam logic [7:0] A_STN_HI = 8'h14;
	localparam logic [7:0] A_CNT0 = 8'h20;
	localparam logic [7:0] A_CNT_LAST = 8'h4c;
	// Counter indices, each at A_CNT0 + 4 * index
	localparam int NCNT = 12;
	localparam int C_NP_FRM = 0;
	localparam int C_NP_OCT = 1;
	localparam int C_ZERO_DEST = 2;
	localparam int C_UNREAD_OCT = 3;
	localparam int C_TOO_LONG = 4;
	localparam int C_MARKED = 5;
	localparam int C_BAD_DATA = 6;
	localparam int C_GOOD_FRM = 7;
	localparam int C_GOOD_OCT = 8;
	localparam int C_PROMO = 9;
	localparam int C_ADDR_CHG = 10;
	localparam int C_TRN_ENTRY = 11;
	// Control register fields and reset values
	localparam int CTRL_EN = 0;
	localparam int CTRL_PRIO = 1;
	localparam int CTRL_FRAMING = 2;
	localparam logic CTRL_EN_RST = 1'b1;
	localparam logic CTRL_PRIO_RST = 1'b1;
	localparam logic CTRL_FRAMING_RST = 1'b0;
	// Status register field positions
	localparam int ST_STATE_LSB = 0;
	localparam int ST_KIND_LSB = 2;
	localparam int ST_CASC_LSB = 4;
	localparam int ST_FILT_LSB = 6;
	localparam int ST_VER_LSB = 8;
	localparam int VER_W = 3;
	// Oversize thresholds in octets
	localparam logic [15:0] OVERSIZE_ETH = 16'h05ef;
	localparam logic [15:0] OVERSIZE_TR = 16'h11a9;
	// Error-free training packets needed for link good
	localparam logic [4:0] LINK_OK_RUN = 5'h18;
	localparam int OUTCOME_W = 18;
	typedef enum logic [1:0] {ST_INACTIVE, ST_TRAINING, ST_ACTIVE} rpm_state_e;
	typedef enum logic [1:0] {K_CASC_INT, K_CASC_EXT, K_LOCAL_INT, K_LOCAL_EXT} rpm_kind_e;
	typedef enum logic [1:0] {CC_END_ONLY, CC_END_OR_RPT, CC_CASCADE} rpm_casc_e;
	typedef enum logic [1:0] {FC_SINGLE, FC_SINGLE_OR_PROM, FC_PROM_ONLY} rpm_filt_e;
	typedef enum logic [1:0] {LK_ACTIVATE, LK_STANDBY, LK_DISABLE} rpm_link_e;
endpackage

// ==== core/rpm_rx_if.sv ====
interface rpm_rx_if;
	logic frm_end;
	logic [15:0] frm_len;
	logic dest_zero;
	logic marked;
	logic data_err;
	logic framing_tr;
	logic too_long;
	logic zero_dest;
	logic marked_err;
	logic bad_data;
	logic good;
	logic trn_pkt;
	logic trn_err;
	logic [15:0] trn_cfg;
	logic trn_clr;
	logic [rpm_pkg::OUTCOME_W-1:0] outcome;
	modport cls (input frm_end, frm_len, dest_zero, marked, data_err, framing_tr,
		output too_long, zero_dest, marked_err, bad_data, good);
	modport trk (input trn_pkt, trn_err, trn_cfg, trn_clr, output outcome);
endinterface

// ==== core/rpm_frame_class.sv ====
module rpm_frame_class (
	rpm_rx_if.cls rx
);
	logic [15:0] limit;

	// Each frame lands in exactly one class; zero address outranks length
	always_comb
	begin
		limit = rx.framing_tr ? rpm_pkg::OVERSIZE_TR : rpm_pkg::OVERSIZE_ETH;
		// Classes only raised in the frame-end cycle
		rx.zero_dest = rx.frm_end && rx.dest_zero;
		rx.too_long = rx.frm_end && !rx.dest_zero && rx.frm_len >= limit;
		rx.marked_err = rx.frm_end && !rx.dest_zero && !rx.too_long && rx.marked;
		rx.bad_data = rx.frm_end && !rx.dest_zero && !rx.too_long && !rx.marked &&
			rx.data_err;
		rx.good = rx.frm_end &&
			!(rx.zero_dest || rx.too_long || rx.marked_err || rx.bad_data);
	end
endmodule

// ==== core/rpm_train_track.sv ====
module rpm_train_track (
	input wire logic pclk,
	input wire logic presetn,
	rpm_rx_if.trk rx
);
	typedef struct packed {
		logic [15:0] cfg;
		logic link_ok;
		logic valid;
		logic [4:0] run;
	} rpm_trk_s;

	rpm_trk_s s;
	rpm_trk_s next_s;

	always_comb
	begin
		next_s = s;
		if (rx.trn_clr)
		begin
			next_s.link_ok = 1'b0;
			next_s.valid = 1'b0;
			next_s.run = 5'h00;
		end
		// A packet in the clearing cycle still counts
		if (rx.trn_pkt && rx.trn_err)
		begin
			next_s.run = 5'h00;
			next_s.link_ok = 1'b0;
		end
		else if (rx.trn_pkt)
		begin
			next_s.cfg = rx.trn_cfg;
			next_s.valid = 1'b1;
			if (next_s.run < rpm_pkg::LINK_OK_RUN)
				next_s.run = next_s.run + 5'h01;
			if (next_s.run == rpm_pkg::LINK_OK_RUN)
				next_s.link_ok = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign rx.outcome = {s.cfg, s.link_ok, s.valid};

	property p_link_ok;
		@(posedge pclk) disable iff (!presetn)
		rx.trn_pkt && !rx.trn_err && !rx.trn_clr && s.run == 5'h17 |=> s.link_ok;
	endproperty
	a_link_ok: assert property (p_link_ok) else $error("link good not set on 24th packet");

	property p_link_drop;
		@(posedge pclk) disable iff (!presetn)
		rx.trn_pkt && rx.trn_err |=> !s.link_ok && s.run == 5'h00;
	endproperty
	a_link_drop: assert property (p_link_drop) else $error("errored packet kept link good");

	property p_valid;
		@(posedge pclk) disable iff (!presetn)
		(rx.trn_clr && !rx.trn_pkt |=> !s.valid) and
		(rx.trn_pkt && !rx.trn_err |=> s.valid && s.cfg == $past(rx.trn_cfg));
	endproperty
	a_valid: assert property (p_valid) else $error("valid flag or stored config wrong");
endmodule

// ==== core/rpm_port_mgmt.sv ====
module rpm_port_mgmt #(
	parameter logic [7:0] PORT_INDEX = 8'h01,
	parameter logic [7:0] GROUP_CAPACITY = 8'h08,
	parameter rpm_pkg::rpm_kind_e PORT_KIND = rpm_pkg::K_LOCAL_EXT,
	parameter rpm_pkg::rpm_casc_e LOCAL_CASC_CAP = rpm_pkg::CC_END_OR_RPT,
	parameter rpm_pkg::rpm_filt_e LOCAL_FILT_CAP = rpm_pkg::FC_SINGLE_OR_PROM,
	parameter logic [rpm_pkg::VER_W-1:0] TRAIN_VERSION = 3'h1,
	parameter logic HAS_SECONDARY = 1'b0
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rptr_reset,
	input wire logic frm_end,
	input wire logic [15:0] frm_len,
	input wire logic frm_dest_zero,
	input wire logic frm_marked,
	input wire logic frm_data_err,
	input wire logic frm_high,
	input wire logic promo_event,
	input wire logic trn_pkt,
	input wire logic trn_err,
	input wire logic [15:0] trn_cfg,
	input wire logic trained_ok,
	input wire logic [47:0] trained_addr,
	input wire rpm_pkg::rpm_state_e meta_state,
	input wire logic hp_request,
	output logic port_enable,
	output logic train_start,
	output logic link_stb,
	output rpm_pkg::rpm_link_e link_pri_ctl,
	output rpm_pkg::rpm_link_e link_sec_ctl,
	output logic hp_grant
);
	localparam logic IS_CASCADE = PORT_KIND == rpm_pkg::K_CASC_INT ||
		PORT_KIND == rpm_pkg::K_CASC_EXT;

	typedef struct packed {
		logic [rpm_pkg::NCNT-1:0][31:0] cnt;
		logic [47:0] station;
		logic admin_en;
		logic prio_allow;
		logic framing_tr;
		rpm_pkg::rpm_state_e prev_state;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic train_start;
		logic link_stb;
		logic hp_grant;
		rpm_pkg::rpm_link_e link_pri;
		rpm_pkg::rpm_link_e link_sec;
	} rpm_main_s;

	rpm_main_s s;
	rpm_main_s next_s;
	rpm_rx_if rx();
	logic [31:0] rd_data;
	logic rd_hit;
	logic [3:0] cnt_idx;
	logic [31:0] octets;
	logic wr_ctrl;
	logic rx_take;
	logic enter_clr;

	// Wrapping 32-bit add
	function automatic logic [31:0] bump(input logic [31:0] v, input logic [31:0] add);
		bump = v + add;
	endfunction

	rpm_frame_class u_class (
		.rx(rx)
	);

	rpm_train_track u_track (
		.pclk(pclk),
		.presetn(presetn),
		.rx(rx)
	);

	assign rx.frm_end = frm_end;
	assign rx.frm_len = frm_len;
	assign rx.dest_zero = frm_dest_zero;
	assign rx.marked = frm_marked;
	assign rx.data_err = frm_data_err;
	assign rx.framing_tr = s.framing_tr;
	assign rx.trn_pkt = trn_pkt && s.admin_en;
	assign rx.trn_err = trn_err;
	assign rx.trn_cfg = trn_cfg;
	// Clear on entry into inactive or training, or on repeater reset
	assign enter_clr = meta_state != s.prev_state && meta_state != rpm_pkg::ST_ACTIVE;
	assign rx.trn_clr = enter_clr || rptr_reset;

	assign octets = {16'h0000, frm_len};
	assign rx_take = frm_end && s.admin_en;
	assign wr_ctrl = psel && penable && s.pready && pwrite && paddr == rpm_pkg::A_CTRL;
	assign cnt_idx = 4'((paddr - rpm_pkg::A_CNT0) >> 2);

	// Read decode
	always_comb
	begin
		rd_data = 32'h0000_0000;
		rd_hit = 1'b1;
		if (paddr[1:0] != 2'h0)
			rd_hit = 1'b0;
		else if (paddr == rpm_pkg::A_CTRL)
		begin
			rd_data[rpm_pkg::CTRL_EN] = s.admin_en;
			rd_data[rpm_pkg::CTRL_PRIO] = s.prio_allow;
			rd_data[rpm_pkg::CTRL_FRAMING] = s.framing_tr;
		end
		else if (paddr == rpm_pkg::A_STATUS)
		begin
			rd_data[rpm_pkg::ST_STATE_LSB +: 2] = meta_state;
			rd_data[rpm_pkg::ST_KIND_LSB +: 2] = PORT_KIND;
			rd_data[rpm_pkg::ST_CASC_LSB +: 2] = IS_CASCADE ? rpm_pkg::CC_CASCADE
				: LOCAL_CASC_CAP;
			rd_data[rpm_pkg::ST_FILT_LSB +: 2] = IS_CASCADE ? rpm_pkg::FC_PROM_ONLY
				: LOCAL_FILT_CAP;
			rd_data[rpm_pkg::ST_VER_LSB +: rpm_pkg::VER_W] = TRAIN_VERSION;
		end
		else if (paddr == rpm_pkg::A_ID)
			rd_data = {16'h0000, GROUP_CAPACITY, PORT_INDEX};
		else if (paddr == rpm_pkg::A_TRAIN)
			rd_data = {14'h0000, rx.outcome};
		else if (paddr == rpm_pkg::A_STN_LO)
			rd_data = s.station[31:0];
		else if (paddr == rpm_pkg::A_STN_HI)
			rd_data = {16'h0000, s.station[47:32]};
		else if (paddr >= rpm_pkg::A_CNT0 && paddr <= rpm_pkg::A_CNT_LAST)
			rd_data = s.cnt[cnt_idx];
		else
			rd_hit = 1'b0;
	end

	always_comb
	begin
		next_s = s;
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		next_s.train_start = 1'b0;
		next_s.link_stb = 1'b0;
		next_s.prev_state = meta_state;
		next_s.hp_grant = hp_request && s.admin_en && (s.prio_allow || IS_CASCADE);
		// One wait-free access cycle after each setup cycle
		if (psel && !penable)
		begin
			next_s.pready = 1'b1;
			next_s.pslverr = !rd_hit;
			next_s.prdata = (pwrite || !rd_hit) ? 32'h0000_0000 : rd_data;
		end
		if (wr_ctrl)
		begin
			next_s.prio_allow = pwdata[rpm_pkg::CTRL_PRIO];
			next_s.framing_tr = pwdata[rpm_pkg::CTRL_FRAMING];
			next_s.admin_en = pwdata[rpm_pkg::CTRL_EN];
			if (pwdata[rpm_pkg::CTRL_EN] && !s.admin_en)
			begin
				next_s.train_start = 1'b1;
				next_s.link_stb = 1'b1;
				next_s.link_pri = rpm_pkg::LK_ACTIVATE;
				next_s.link_sec = HAS_SECONDARY ? rpm_pkg::LK_STANDBY
					: rpm_pkg::LK_DISABLE;
			end
			else if (!pwdata[rpm_pkg::CTRL_EN] && s.admin_en)
			begin
				next_s.link_stb = 1'b1;
				next_s.link_pri = rpm_pkg::LK_DISABLE;
				next_s.link_sec = rpm_pkg::LK_DISABLE;
			end
		end
		// Frame classified by u_class; counted once at its end
		if (rx_take)
		begin
			if (!frm_high)
			begin
				next_s.cnt[rpm_pkg::C_NP_FRM] = bump(s.cnt[rpm_pkg::C_NP_FRM], 32'h1);
				next_s.cnt[rpm_pkg::C_NP_OCT] = bump(s.cnt[rpm_pkg::C_NP_OCT], octets);
			end
			if (rx.zero_dest)
				next_s.cnt[rpm_pkg::C_ZERO_DEST] = bump(s.cnt[rpm_pkg::C_ZERO_DEST],
					32'h1);
			if (rx.too_long)
				next_s.cnt[rpm_pkg::C_TOO_LONG] = bump(s.cnt[rpm_pkg::C_TOO_LONG],
					32'h1);
			if (rx.marked_err)
				next_s.cnt[rpm_pkg::C_MARKED] = bump(s.cnt[rpm_pkg::C_MARKED], 32'h1);
			if (rx.bad_data)
				next_s.cnt[rpm_pkg::C_BAD_DATA] = bump(s.cnt[rpm_pkg::C_BAD_DATA], 32'h1);
			if (rx.good)
			begin
				next_s.cnt[rpm_pkg::C_GOOD_FRM] = bump(s.cnt[rpm_pkg::C_GOOD_FRM],
					32'h1);
				next_s.cnt[rpm_pkg::C_GOOD_OCT] = bump(s.cnt[rpm_pkg::C_GOOD_OCT],
					octets);
			end
			else
				next_s.cnt[rpm_pkg::C_UNREAD_OCT] = bump(s.cnt[rpm_pkg::C_UNREAD_OCT],
					octets);
		end
		if (promo_event && s.admin_en)
			next_s.cnt[rpm_pkg::C_PROMO] = bump(s.cnt[rpm_pkg::C_PROMO], 32'h1);
		// Cascade port keeps the null station
		if (trained_ok && s.admin_en && !IS_CASCADE && trained_addr != s.station)
		begin
			next_s.station = trained_addr;
			next_s.cnt[rpm_pkg::C_ADDR_CHG] = bump(s.cnt[rpm_pkg::C_ADDR_CHG], 32'h1);
		end
		if (meta_state == rpm_pkg::ST_TRAINING && s.prev_state != rpm_pkg::ST_TRAINING)
			next_s.cnt[rpm_pkg::C_TRN_ENTRY] = bump(s.cnt[rpm_pkg::C_TRN_ENTRY],
				32'h1);
		// Repeater reset cancels pulses and grant but keeps settings and counters
		if (rptr_reset)
		begin
			next_s.train_start = 1'b0;
			next_s.link_stb = 1'b0;
			next_s.hp_grant = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s <= '0;
			s.admin_en <= rpm_pkg::CTRL_EN_RST;
			s.prio_allow <= rpm_pkg::CTRL_PRIO_RST;
			s.framing_tr <= rpm_pkg::CTRL_FRAMING_RST;
			s.link_sec <= rpm_pkg::LK_DISABLE;
		end
		else
			s <= next_s;
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign port_enable = s.admin_en;
	assign train_start = s.train_start;
	assign link_stb = s.link_stb;
	assign link_pri_ctl = s.link_pri;
	assign link_sec_ctl = s.link_sec;
	assign hp_grant = s.hp_grant;

	property p_np_octets;
		@(posedge pclk) disable iff (!presetn)
		rx_take && !frm_high |=> s.cnt[rpm_pkg::C_NP_OCT] ==
			$past(s.cnt[rpm_pkg::C_NP_OCT]) + $past(octets);
	endproperty
	a_np_octets: assert property (p_np_octets) else $error("normal octets not summed");

	property p_zero_dest;
		@(posedge pclk) disable iff (!presetn)
		rx_take && frm_dest_zero |=> s.cnt[rpm_pkg::C_ZERO_DEST] ==
			$past(s.cnt[rpm_pkg::C_ZERO_DEST]) + 32'h1;
	endproperty
	a_zero_dest: assert property (p_zero_dest) else $error("zero address frame missed");

	property p_unread;
		@(posedge pclk) disable iff (!presetn)
		rx_take && (frm_marked || frm_data_err) |=> s.cnt[rpm_pkg::C_UNREAD_OCT] ==
			$past(s.cnt[rpm_pkg::C_UNREAD_OCT]) + $past(octets) &&
			$stable(s.cnt[rpm_pkg::C_GOOD_FRM]);
	endproperty
	a_unread: assert property (p_unread) else $error("unreadable octets wrong");

	property p_oversize;
		@(posedge pclk) disable iff (!presetn)
		rx_take && !frm_dest_zero && frm_len >= (s.framing_tr ? 16'h11a9 : 16'h05ef)
			|=> s.cnt[rpm_pkg::C_TOO_LONG] == $past(s.cnt[rpm_pkg::C_TOO_LONG]) + 32'h1;
	endproperty
	a_oversize: assert property (p_oversize) else $error("oversize frame missed");

	property p_disabled;
		@(posedge pclk) disable iff (!presetn)
		!s.admin_en && frm_end |=> $stable(s.cnt[rpm_pkg::C_NP_FRM]) &&
			$stable(s.cnt[rpm_pkg::C_GOOD_FRM]);
	endproperty
	a_disabled: assert property (p_disabled) else $error("disabled port counted frame");

	property p_enable;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl && pwdata[0] && !s.admin_en && !rptr_reset |=>
			train_start && link_stb && port_enable ##1 !train_start;
	endproperty
	a_enable: assert property (p_enable) else $error("enable did not start training");

	property p_disable_links;
		@(posedge pclk) disable iff (!presetn)
		wr_ctrl && !pwdata[0] && s.admin_en |=> link_pri_ctl == rpm_pkg::LK_DISABLE &&
			link_sec_ctl == rpm_pkg::LK_DISABLE && !port_enable;
	endproperty
	a_disable_links: assert property (p_disable_links) else $error("links left on");

	property p_hp;
		@(posedge pclk) disable iff (!presetn)
		hp_request && !s.prio_allow && !IS_CASCADE |=> !hp_grant;
	endproperty
	a_hp: assert property (p_hp) else $error("high priority granted while off");

	property p_good;
		@(posedge pclk) disable iff (!presetn)
		rx_take && !frm_dest_zero && !frm_marked && !frm_data_err && frm_len < 16'h05ef
			|=> s.cnt[rpm_pkg::C_GOOD_FRM] == $past(s.cnt[rpm_pkg::C_GOOD_FRM]) + 32'h1;
	endproperty
	a_good: assert property (p_good) else $error("good frame not counted");

	property p_entry;
		@(posedge pclk) disable iff (!presetn)
		meta_state == rpm_pkg::ST_TRAINING && s.prev_state == rpm_pkg::ST_ACTIVE |=>
			s.cnt[rpm_pkg::C_TRN_ENTRY] == $past(s.cnt[rpm_pkg::C_TRN_ENTRY]) + 32'h1;
	endproperty
	a_entry: assert property (p_entry) else $error("training entry not counted");

	property p_index;
		@(posedge pclk) disable iff (!presetn)
		PORT_INDEX != 8'h00 && PORT_INDEX <= GROUP_CAPACITY;
	endproperty
	a_index: assert property (p_index) else $error("port index out of range");
endmodule

// ==== tb/rpm_lme_model.sv ====
module rpm_lme_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;

	initial
	begin
		{psel, penable, pwrite} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end

	// One transfer; request held until pready is seen high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
		begin
			@(posedge pclk);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ==== tb/test_repeater_port_mgmt_stats.sv ====
module test_repeater_port_mgmt_stats;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic rptr_reset, frm_end, frm_dest_zero, frm_marked, frm_data_err, frm_high;
	logic promo_event, trn_pkt, trn_err, trained_ok, hp_request, e;
	logic [15:0] frm_len, trn_cfg;
	logic [47:0] trained_addr;
	rpm_pkg::rpm_state_e meta_state;
	logic port_enable, train_start, link_stb, hp_grant;
	rpm_pkg::rpm_link_e link_pri_ctl, link_sec_ctl, pri_s, sec_s;
	int n_errors = 0;
	int checked = 0;
	int n_ts = 0;
	int n_ls = 0;
	logic [31:0] exp_c [12];

	rpm_port_mgmt rpm_port_mgmt_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .rptr_reset, .frm_end, .frm_len,
		.frm_dest_zero, .frm_marked, .frm_data_err, .frm_high, .promo_event, .trn_pkt,
		.trn_err, .trn_cfg, .trained_ok, .trained_addr, .meta_state, .hp_request,
		.port_enable, .train_start, .link_stb, .link_pri_ctl, .link_sec_ctl, .hp_grant);

	rpm_lme_model rpm_lme_model_i (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);

	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Count one-shot pulses and keep the last link action
	always @(posedge pclk)
	begin
		if (train_start === 1'b1)
			n_ts++;
		if (link_stb === 1'b1)
		begin
			n_ls++;
			pri_s <= link_pri_ctl;
			sec_s <= link_sec_ctl;
		end
	end

	task complete_run;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] x);
		rpm_lme_model_i.xfer(1'b0, a, 32'h0, r, e);
		chk(r, x);
		chk({31'h0, e}, 32'h0);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		rpm_lme_model_i.xfer(1'b1, a, d, r, e);
	endtask

	task cnts;
		for (int i = 0; i < rpm_pkg::NCNT; i++)
			rchk(rpm_pkg::A_CNT0 + 8'(4 * i), exp_c[i]);
	endtask

	// Flags are {dest zero, marked, data error, high}
	task frame(input logic [15:0] n, input logic [3:0] f);
		@(posedge pclk);
		frm_end <= 1'b1;
		frm_len <= n;
		{frm_dest_zero, frm_marked, frm_data_err, frm_high} <= f;
		@(posedge pclk);
		frm_end <= 1'b0;
	endtask

	// k training packets on consecutive cycles
	task trn(input logic er, input int k);
		@(posedge pclk);
		trn_pkt <= 1'b1;
		trn_err <= er;
		repeat (k) @(posedge pclk);
		trn_pkt <= 1'b0;
	endtask

	task t_reset_vals;
		rchk(rpm_pkg::A_CTRL, 32'h3);
		rchk(rpm_pkg::A_STATUS, 32'h15c);
		rchk(rpm_pkg::A_ID, 32'h801);
		rchk(rpm_pkg::A_TRAIN, 32'h0);
		wr(rpm_pkg::A_STATUS, 32'hffffffff);
		rchk(rpm_pkg::A_STATUS, 32'h15c);
		rpm_lme_model_i.xfer(1'b0, 8'h18, 32'h0, r, e);
		chk({31'h0, e}, 32'h1);
		exp_c = '{default: 32'h0};
		cnts;
	endtask

	task t_frames;
		frame(16'h0064, 4'h0);
		frame(16'h05ee, 4'h0);
		frame(16'h05ef, 4'h0);
		frame(16'h0040, 4'h8);
		frame(16'h0046, 4'h4);
		frame(16'h0050, 4'h2);
		frame(16'h005a, 4'h1);
		frame(16'h07d0, 4'hf);
		wr(rpm_pkg::A_CTRL, 32'h7);
		frame(16'h11a8, 4'h0);
		frame(16'h11a9, 4'h0);
		exp_c = '{32'h8, 32'h3068, 32'h2, 32'h203e, 32'h2, 32'h1, 32'h1, 32'h4,
			32'h1854, 32'h0, 32'h0, 32'h0};
		cnts;
	endtask

	task t_admin;
		wr(rpm_pkg::A_CTRL, 32'h6);
		repeat (2) @(posedge pclk);
		chk({31'h0, port_enable}, 32'h0);
		chk({28'h0, pri_s, sec_s}, 32'ha);
		frame(16'h0064, 4'h0);
		rchk(rpm_pkg::A_CNT0, 32'h8);
		wr(rpm_pkg::A_CTRL, 32'h6);
		wr(rpm_pkg::A_CTRL, 32'h7);
		repeat (2) @(posedge pclk);
		chk(n_ts, 32'h1);
		chk(n_ls, 32'h2);
		chk({28'h0, pri_s, sec_s}, 32'h2);
		chk({31'h0, port_enable}, 32'h1);
	endtask

	task t_training;
		@(posedge pclk);
		meta_state <= rpm_pkg::ST_TRAINING;
		trn_cfg <= 16'h5a3c;
		trn(1'b0, 23);
		rchk(rpm_pkg::A_TRAIN, 32'h168f1);
		trn(1'b0, 1);
		rchk(rpm_pkg::A_TRAIN, 32'h168f3);
		trn(1'b1, 1);
		rchk(rpm_pkg::A_TRAIN, 32'h168f1);
		rchk(rpm_pkg::A_STATUS, 32'h15d);
		@(posedge pclk);
		meta_state <= rpm_pkg::ST_ACTIVE;
		@(posedge pclk);
		meta_state <= rpm_pkg::ST_TRAINING;
		rpm_lme_model_i.xfer(1'b0, rpm_pkg::A_TRAIN, 32'h0, r, e);
		chk({30'h0, r[1:0]}, 32'h0);
		rchk(rpm_pkg::A_CNT_LAST, 32'h2);
		@(posedge pclk);
		meta_state <= rpm_pkg::ST_ACTIVE;
		trn(1'b0, 1);
		rchk(rpm_pkg::A_TRAIN, 32'h168f1);
		@(posedge pclk);
		rptr_reset <= 1'b1;
		@(posedge pclk);
		rptr_reset <= 1'b0;
		rchk(rpm_pkg::A_TRAIN, 32'h168f0);
		rchk(rpm_pkg::A_CTRL, 32'h7);
		rchk(rpm_pkg::A_CNT0, 32'h8);
	endtask

	task t_prio;
		@(posedge pclk);
		hp_request <= 1'b1;
		repeat (2) @(posedge pclk);
		#1 chk({31'h0, hp_grant}, 32'h1);
		wr(rpm_pkg::A_CTRL, 32'h5);
		repeat (2) @(posedge pclk);
		#1 chk({31'h0, hp_grant}, 32'h0);
		@(posedge pclk);
		hp_request <= 1'b0;
		wr(rpm_pkg::A_CTRL, 32'h7);
	endtask

	task t_events;
		@(posedge pclk);
		promo_event <= 1'b1;
		trained_ok <= 1'b1;
		trained_addr <= 48'h0000000000a1;
		@(posedge pclk);
		@(posedge pclk);
		promo_event <= 1'b0;
		trained_addr <= 48'hab12cd34ef56;
		@(posedge pclk);
		trained_ok <= 1'b0;
		rchk(rpm_pkg::A_CNT0 + 8'h24, 32'h2);
		rchk(rpm_pkg::A_CNT0 + 8'h28, 32'h2);
		rchk(rpm_pkg::A_STN_LO, 32'hcd34ef56);
		rchk(rpm_pkg::A_STN_HI, 32'h0000ab12);
	endtask

	initial
	begin
		presetn = 1'b0;
		{rptr_reset, frm_end, frm_dest_zero, frm_marked, frm_data_err, frm_high} = 6'h0;
		{promo_event, trn_pkt, trn_err, trained_ok, hp_request} = 5'h0;
		{frm_len, trn_cfg, trained_addr} = 80'h0;
		meta_state = rpm_pkg::ST_INACTIVE;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_vals;
		t_frames;
		t_admin;
		t_training;
		t_prio;
		t_events;
		complete_run;
	end

	initial
	begin
		#200us;
		n_errors++;
		complete_run;
	end
endmodule
